// *** sbw_pkg.sv ***
`default_nettype none
package sbw_pkg;
    // word layouts of the four array variants
    typedef enum {
        SBW_X8,
        SBW_X9,
        SBW_X18,
        SBW_X36
    } sbw_variant_t;

    localparam int DATA_W = 36;          // widest word; narrower variants use the low bits
    localparam int SEL_W = 4;            // widest lane select group
    localparam int ADDR_W = 8;           // burst address width held in this model
    localparam int MEM_DEPTH = 2 ** (ADDR_W + 1);
    localparam int LANE_W_NIBBLE = 4;    // x8 lanes are nibbles
    localparam int LANE_W_BYTE = 9;      // x9, x18 and x36 lanes are 9-bit bytes
    localparam int LANES_X8 = 2;
    localparam int LANES_X9 = 1;
    localparam int LANES_X18 = 2;
    localparam int LANES_X36 = 4;
    localparam int WR_DATA_CYCLE = 1;    // first write word at cycle t+1
    localparam int RD_DATA_CYCLE = 2;    // first read word at cycle t+2
    localparam int SYNC_STAGES = 3;
    localparam logic [DATA_W-1:0] Q_RESET = 36'h0_0000_0000;

    // pins from the memory controller, all outside the i_clk domain
    typedef struct packed {
        logic k;
        logic k_n;
        logic load_n;
        logic read_not_write;
        logic [ADDR_W-1:0] addr;
        logic [SEL_W-1:0] lane_write_select_n;
        logic [DATA_W-1:0] d;
    } sbw_pins_t;
endpackage : sbw_pkg
`default_nettype wire

// *** sbw_pin_sync.sv ***
`default_nettype none
module sbw_pin_sync
    import sbw_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    // three-stage chain; ff1 feeds only ff2
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ff1_r <= '0;
            ff2_r <= '0;
            ff3_r <= '0;
        end else if (i_ce) begin
            ff1_r <= i_d;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // a bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_q[i] <= 1'b0;
                end else if (i_ce && (ff2_r[i] == ff3_r[i])) begin
                    o_q[i] <= ff3_r[i];
                end
            end
        end
    endgenerate
endmodule : sbw_pin_sync
`default_nettype wire

// *** sbw_core.sv ***
`default_nettype none
// Operation
// - word one at K t+1, two at K#
// - data captured and driven on both clocks
// - first word at A, second at A+1
// - cycles counted from operation start t
// - x8/x18 both selects low write whole word
// - select0 only writes lower lane
// - select1 only writes upper lane
// - x8/x18 both selects high write nothing
// - x9 single select gates whole word
// - x36 all selects low write 36 bits
// - x36 select0 alone writes bits 8..0
// - x36 select 1/2/3 alone write own byte
// - x9/x36 all selects high write nothing
// - selects sampled separately per data word
// - powers up deselected, outputs high impedance
module sbw_core
    import sbw_pkg::*;
#(
    parameter sbw_variant_t VARIANT = SBW_X18
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire sbw_pins_t i_pins,
    output logic [DATA_W-1:0] o_q,
    output logic o_q_oe
);
    localparam int LW = (VARIANT == SBW_X8) ? LANE_W_NIBBLE : LANE_W_BYTE;
    localparam int NL = (VARIANT == SBW_X8) ? LANES_X8 :
                        (VARIANT == SBW_X9) ? LANES_X9 :
                        (VARIANT == SBW_X18) ? LANES_X18 : LANES_X36;
    localparam logic [DATA_W-1:0] LANE0_MASK = DATA_W'((64'h1 << LW) - 64'h1);
    localparam logic [DATA_W-1:0] FULL_MASK = DATA_W'((64'h1 << (LW * NL)) - 64'h1);
    localparam logic [DATA_W-1:0] LANE1_MASK = (NL > 1) ? DATA_W'(LANE0_MASK << LW) : '0;
    localparam logic [DATA_W-1:0] LANE2_MASK = (NL > 2) ? DATA_W'(LANE0_MASK << (2 * LW)) : '0;
    localparam logic [DATA_W-1:0] LANE3_MASK = (NL > 3) ? DATA_W'(LANE0_MASK << (3 * LW)) : '0;

    sbw_pins_t s;
    logic k_prev_r;
    logic kn_prev_r;
    logic k_rise;
    logic kn_rise;
    logic wr0_pend_r;
    logic wr1_pend_r;
    logic [ADDR_W-1:0] wa0_r;
    logic [ADDR_W-1:0] wa1_r;
    logic rd1_r;
    logic rd2_r;
    logic rd_hi_r;
    logic [ADDR_W-1:0] ra1_r;
    logic [ADDR_W-1:0] ra2_r;
    logic [ADDR_W-1:0] rah_r;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic wr_go;
    logic [ADDR_W:0] wr_idx;
    logic [DATA_W-1:0] wr_mask;
    logic [DATA_W-1:0] wr_old;
    logic [DATA_W-1:0] wr_new;
    logic [DATA_W-1:0] rd_word0;
    logic [DATA_W-1:0] rd_word1;

    // every pin crosses four flops before use
    sbw_pin_sync #(
        .W($bits(sbw_pins_t))
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(i_pins),
        .o_q(s)
    );

    // rising edges of the two input clocks, as seen on i_clk
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            k_prev_r <= 1'b1;
            kn_prev_r <= 1'b1;
        end else if (i_ce) begin
            k_prev_r <= s.k;
            kn_prev_r <= s.k_n;
        end
    end
    assign k_rise = i_ce && s.k && !k_prev_r;
    assign kn_rise = i_ce && s.k_n && !kn_prev_r;

    // write sequencing: start at t, word one at K of t+1, word two at K# after
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr0_pend_r <= 1'b0;
            wr1_pend_r <= 1'b0;
            wa0_r <= '0;
            wa1_r <= '0;
        end else begin
            if (k_rise) begin
                wr0_pend_r <= !s.load_n && !s.read_not_write;
                if (!s.load_n && !s.read_not_write) begin
                    wa0_r <= s.addr;
                end
                if (wr0_pend_r) begin
                    wr1_pend_r <= 1'b1;
                    wa1_r <= wa0_r;
                end
            end
            if (kn_rise && !(k_rise && wr0_pend_r)) begin
                wr1_pend_r <= 1'b0;
            end
        end
    end

    // one array write per data word; selects are those seen with that word
    assign wr_go = (k_rise && wr0_pend_r) || (kn_rise && wr1_pend_r);
    assign wr_idx = (k_rise && wr0_pend_r) ? {wa0_r, 1'b0} : {wa1_r, 1'b1};

    // per-bit enable from the active-low select of the bit's lane
    genvar j;
    generate
        for (j = 0; j < DATA_W; j++) begin : g_mask
            if (j < LW * NL) begin : g_used
                assign wr_mask[j] = !s.lane_write_select_n[j / LW];
            end else begin : g_unused
                assign wr_mask[j] = 1'b0;
            end
        end
    endgenerate

    // unselected lanes keep the stored bits
    assign wr_old = mem[wr_idx];
    assign wr_new = (wr_old & ~wr_mask) | (s.d & wr_mask);

    always_ff @(posedge i_clk) begin
        if (wr_go) begin
            mem[wr_idx] <= wr_new;
        end
    end

    // read pipeline: start at t, data on K and K# of t+2
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd1_r <= 1'b0;
            rd2_r <= 1'b0;
            ra1_r <= '0;
            ra2_r <= '0;
        end else if (k_rise) begin
            rd1_r <= !s.load_n && s.read_not_write;
            ra1_r <= s.addr;
            rd2_r <= rd1_r;
            ra2_r <= ra1_r;
        end
    end

    assign rd_word0 = mem[{ra2_r, 1'b0}];
    assign rd_word1 = mem[{rah_r, 1'b1}];

    // drivers off from reset and after any K rise with no read due
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_q <= Q_RESET;
            o_q_oe <= 1'b0;
            rd_hi_r <= 1'b0;
            rah_r <= '0;
        end else if (k_rise) begin
            o_q_oe <= rd2_r;
            rd_hi_r <= rd2_r;
            rah_r <= ra2_r;
            if (rd2_r) begin
                o_q <= rd_word0;
            end
        end else if (kn_rise && rd_hi_r) begin
            o_q <= rd_word1;
            rd_hi_r <= 1'b0;
        end
    end

    // checks
    property p_wr_arm;
        @(posedge i_clk) disable iff (i_rst)
        (k_rise && !s.load_n && !s.read_not_write) |=> wr0_pend_r;
    endproperty
    a_wr_arm: assert property (p_wr_arm) else $error("write start did not arm word one");

    property p_word_two;
        @(posedge i_clk) disable iff (i_rst)
        (k_rise && wr0_pend_r) |=> (wr1_pend_r && {wa1_r, 1'b1} == $past(wr_idx) + 1'b1);
    endproperty
    a_word_two: assert property (p_word_two) else $error("second word not at A+1");

    property p_full;
        @(posedge i_clk) disable iff (i_rst)
        (wr_go && s.lane_write_select_n == 4'h0) |-> wr_mask == FULL_MASK;
    endproperty
    a_full: assert property (p_full) else $error("all selects low did not write whole word");

    // unused high bits are never written and stay unknown, so they are masked off
    property p_none;
        @(posedge i_clk) disable iff (i_rst)
        (wr_go && s.lane_write_select_n == 4'hF) |=>
            (mem[$past(wr_idx)] & FULL_MASK) == ($past(wr_old) & FULL_MASK);
    endproperty
    a_none: assert property (p_none) else $error("write with all selects high changed data");

    property p_lane0;
        @(posedge i_clk) disable iff (i_rst)
        (wr_go && s.lane_write_select_n == 4'hE) |-> wr_mask == LANE0_MASK;
    endproperty
    a_lane0: assert property (p_lane0) else $error("lower lane mask wrong");

    property p_upper;
        @(posedge i_clk) disable iff (i_rst)
        wr_go |-> ((s.lane_write_select_n != 4'hD || wr_mask == LANE1_MASK) &&
                   (s.lane_write_select_n != 4'hB || wr_mask == LANE2_MASK) &&
                   (s.lane_write_select_n != 4'h7 || wr_mask == LANE3_MASK));
    endproperty
    a_upper: assert property (p_upper) else $error("upper lane mask wrong");

    property p_merge;
        @(posedge i_clk) disable iff (i_rst)
        wr_go |=> (mem[$past(wr_idx)] & FULL_MASK) ==
            ((($past(wr_old) & ~$past(wr_mask)) | ($past(s.d) & $past(wr_mask))) & FULL_MASK);
    endproperty
    a_merge: assert property (p_merge) else $error("merge of stored and new lanes wrong");

    property p_read_out;
        @(posedge i_clk) disable iff (i_rst)
        (k_rise && rd2_r) |=> (o_q_oe && (o_q & FULL_MASK) == ($past(rd_word0) & FULL_MASK));
    endproperty
    a_read_out: assert property (p_read_out) else $error("read word not driven at t+2");

    property p_quiet;
        @(posedge i_clk) disable iff (i_rst)
        (k_rise && !rd2_r) |=> !o_q_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs driven without a read");

    c_full: cover property (@(posedge i_clk) disable iff (i_rst)
        wr_go && s.lane_write_select_n == 4'h0);
    c_partial: cover property (@(posedge i_clk) disable iff (i_rst)
        wr_go && s.lane_write_select_n == 4'hE);
    c_read: cover property (@(posedge i_clk) disable iff (i_rst)
        kn_rise && rd_hi_r);
endmodule : sbw_core
`default_nettype wire

// *** sbw_ctrl_model.sv ***
`default_nettype none
module sbw_ctrl_model
    import sbw_pkg::*;
(
    input wire logic i_clk,
    output var sbw_pins_t o_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: both input clocks parked high, no load
    initial begin
        o_pins = '0;
        o_pins.k = 1'b1;
        o_pins.k_n = 1'b1;
        o_pins.load_n = 1'b1;
    end

    // one half cycle: word, selects and controls set together, then one clock rises
    task automatic half(input logic kk, input logic ld_n, input logic rnw,
        input logic [ADDR_W-1:0] a, input logic [SEL_W-1:0] s,
        input logic [DATA_W-1:0] dd);
        @(posedge i_clk);
        o_pins.k <= 1'b0;
        o_pins.k_n <= 1'b0;
        o_pins.load_n <= ld_n;
        o_pins.read_not_write <= rnw;
        o_pins.addr <= a;
        o_pins.lane_write_select_n <= s;
        o_pins.d <= dd;
        // setup and hold must outlast the four-edge pin latency
        repeat (5) @(posedge i_clk);
        o_pins.k <= kk;
        o_pins.k_n <= ~kk;
        repeat (7) @(posedge i_clk);
    endtask : half
endmodule : sbw_ctrl_model
`default_nettype wire

// *** sram_byte_write_mask_tb.sv ***
`default_nettype none
module sram_byte_write_mask_tb
    import sbw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [DATA_W-1:0] N0 = 36'h1_2345_6789;
    localparam logic [DATA_W-1:0] N1 = 36'hE_DCBA_9876;
    logic i_clk;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    sbw_pins_t pins;
    logic [DATA_W-1:0] q [4];
    logic oe [4];
    int err_total = 0;
    int checks_done = 0;
    int wd [4] = '{8, 9, 18, 36};
    logic [ADDR_W-1:0] adr;
    // rows: selects for word one and word two of the masked write
    logic [SEL_W-1:0] s0_tab [6] = '{4'h0, 4'hE, 4'hB, 4'hF, 4'hD, 4'h7};
    logic [SEL_W-1:0] s1_tab [6] = '{4'hF, 4'hD, 4'h7, 4'h0, 4'hE, 4'hB};

    // one core per word layout, all fed from the same pins
    for (genvar gv = 0; gv < 4; gv++) begin : g_var
        sbw_core #(.VARIANT(sbw_variant_t'(gv))) u_sbw_core (
            .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_pins(pins),
            .o_q(q[gv]), .o_q_oe(oe[gv]));
    end

    sbw_ctrl_model u_sbw_ctrl_model (.i_clk(i_clk), .o_pins(pins));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // expected word: new bits in selected lanes, old (inverted) elsewhere
    function automatic logic [DATA_W-1:0] merge(input int v, input logic [SEL_W-1:0] s,
        input logic [DATA_W-1:0] n);
        logic [DATA_W-1:0] m;
        case (v)
            0: m = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
            1: m = {27'h0, {9{~s[0]}}};
            2: m = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
            default: m = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
        endcase
        return ((n & m) | (~n & ~m)) & ({DATA_W{1'b1}} >> (DATA_W - wd[v]));
    endfunction : merge

    task automatic chk(input string nm, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // compare every layout; unused high bits are masked off
    task automatic chk_q(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] n,
        input logic eo);
        @(negedge i_clk);
        for (int v = 0; v < 4; v++) begin
            if (eo) begin
                chk("q", q[v] & ({DATA_W{1'b1}} >> (DATA_W - wd[v])), merge(v, s, n));
            end
            chk("oe", {35'h0, oe[v]}, {35'h0, eo});
        end
    endtask : chk_q

    // one full cycle of the input clocks
    task automatic kc(input logic ld, input logic rw, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d0, input logic [SEL_W-1:0] s0,
        input logic [DATA_W-1:0] d1, input logic [SEL_W-1:0] s1);
        u_sbw_ctrl_model.half(1'b1, ld, rw, a, s0, d0);
        u_sbw_ctrl_model.half(1'b0, ld, rw, a, s1, d1);
    endtask : kc

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        for (int v = 0; v < 4; v++) begin
            chk("reset q", q[v], 36'h0_0000_0000);
            chk("reset oe", {35'h0, oe[v]}, 36'h0_0000_0000);
        end
        // let the synchronisers settle before the first load
        repeat (8) @(posedge i_clk);
        for (int r = 0; r < 6; r++) begin
            adr = (r == 5) ? 8'hFF : 8'(r * 37);
            kc(1'b0, 1'b0, adr, ~N0, 4'hF, ~N1, 4'hF);
            kc(1'b0, 1'b0, adr, ~N0, 4'h0, ~N1, 4'h0);
            kc(1'b0, 1'b1, adr, N0, s0_tab[r], N1, s1_tab[r]);
            kc(1'b1, 1'b0, ~adr, ~N0, 4'hF, ~N1, 4'hF);
            u_sbw_ctrl_model.half(1'b1, 1'b1, 1'b0, ~adr, 4'hF, N0);
            chk_q(s0_tab[r], N0, 1'b1);
            u_sbw_ctrl_model.half(1'b0, 1'b1, 1'b0, ~adr, 4'hF, ~N0);
            chk_q(s1_tab[r], N1, 1'b1);
            u_sbw_ctrl_model.half(1'b1, 1'b1, 1'b0, adr, 4'hF, N1);
            chk_q(4'hF, N1, 1'b0);
            u_sbw_ctrl_model.half(1'b0, 1'b1, 1'b0, adr, 4'hF, ~N1);
        end
        // frozen core: a read issued while the enable is low is never seen
        ce <= 1'b0;
        kc(1'b0, 1'b1, adr, N0, 4'h0, N1, 4'h0);
        kc(1'b1, 1'b0, ~adr, N0, 4'h0, N1, 4'h0);
        u_sbw_ctrl_model.half(1'b1, 1'b1, 1'b0, ~adr, 4'hF, N0);
        @(negedge i_clk);
        for (int v = 0; v < 4; v++) begin
            chk("hold q", q[v] & ~({DATA_W{1'b1}} << wd[v]), merge(v, s1_tab[5], N1));
            chk("hold oe", {35'h0, oe[v]}, 36'h0_0000_0000);
        end
        @(posedge i_clk);
        ce <= 1'b1;
        // mid-run reset clears the outputs but leaves the array alone
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        for (int v = 0; v < 4; v++) begin
            chk("rerun q", q[v], 36'h0_0000_0000);
            chk("rerun oe", {35'h0, oe[v]}, 36'h0_0000_0000);
        end
        repeat (8) @(posedge i_clk);
        kc(1'b0, 1'b1, adr, ~N0, 4'hF, ~N1, 4'hF);
        kc(1'b1, 1'b0, ~adr, ~N0, 4'hF, ~N1, 4'hF);
        u_sbw_ctrl_model.half(1'b1, 1'b1, 1'b0, ~adr, 4'hF, N0);
        chk_q(s0_tab[5], N0, 1'b1);
        u_sbw_ctrl_model.half(1'b0, 1'b1, 1'b0, ~adr, 4'hF, N1);
        chk_q(s1_tab[5], N1, 1'b1);
        test_done();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        test_done();
    end
endmodule : sram_byte_write_mask_tb
`default_nettype wire
